// File: bench/acs_properties.sv
// checker: timing relations seen on the sequencer link
`timescale 1ns/1ps
module acs_properties (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic conversion_start_n,
	input wire logic busy,
	input wire logic [7:0] ctl_byte,
	input wire logic ctl_we,
	input wire logic [9:0] result,
	input wire logic powered
);
	logic [10:0] cnt_ff;
	logic [2:0] ch_ff;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// busy length counter and mirror of the channel address
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= 11'h0;
			ch_ff <= 3'h0;
		end else begin
			cnt_ff <= busy ? cnt_ff + 11'h1 : 11'h0;
			if (ctl_we && ctl_byte[7:3] == 5'h0)
				ch_ff <= ctl_byte[2:0];
		end
	end
	AST_BUSY_RISE: assert property ($fell(conversion_start_n) && !busy
		|=> busy) else $error("busy missed start");
	AST_BUSY_CAUSE: assert property ($rose(busy) |->
		!$past(conversion_start_n) && $past(conversion_start_n, 2))
		else $error("busy without start");
	AST_CONV_TMP: assert property ($fell(busy) && ch_ff == 3'h0
		|-> cnt_ff == 11'(acs_pkg::CYC_CONV_TMP)) else $error("temp time");
	AST_CONV_ANA: assert property ($fell(busy) && ch_ff != 3'h0
		|-> cnt_ff == 11'(acs_pkg::CYC_CONV_ANA)) else $error("conv time");
	AST_RESULT_HOLD: assert property (!$fell(busy) |-> $stable(result))
		else $error("result moved");
	AST_POWER_DOWN: assert property ($fell(busy) && !conversion_start_n
		|-> ##[0:1] !powered) else $error("no power-down");
	AST_POWER_UP: assert property (!powered && conversion_start_n
		|-> ##[0:2] powered) else $error("no power-up");
	AST_STAY_ON: assert property ($fell(busy) && conversion_start_n
		|-> powered) else $error("powered off");
	AST_ACQ_GAP: assert property ($fell(busy) && conversion_start_n
		|=> conversion_start_n [*8]) else $error("start too soon");
endmodule

// File: bench/test_adc_temp_conversion_sequencer.sv
// testbench: both sequencer ends joined over the link
`timescale 1ns/1ps
module test_adc_temp_conversion_sequencer;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wd = 32'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [9:0] smp = 10'h0;
	logic [9:0] tc = 10'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic wreq;
	logic irq;
	logic hold;
	logic [2:0] chan;
	logic [7:0] thr;
	int err_count = 0;
	int n_tests = 0;
	acs_if lnk ();
	acs_dev i_acs_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(lnk),
		.i_sample(smp), .i_temp_code(tc), .o_hold(hold),
		.o_channel_select(chan), .o_overtemp_threshold(thr));
	acs_hst i_acs_hst (.i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(lnk),
		.i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd),
		.o_readdata(rdata), .o_waitrequest(wreq), .o_irq(irq));
	acs_properties i_acs_properties (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.conversion_start_n(lnk.conversion_start_n), .busy(lnk.busy),
		.ctl_byte(lnk.ctl_byte), .ctl_we(lnk.ctl_we),
		.result(lnk.result), .powered(lnk.powered));
	// free-running 50 MHz clock
	always #10 i_clk = ~i_clk;
	task tally_and_finish;
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task stop;
		err_count++;
		$display("ERROR %0t wait ran out", $time);
		tally_and_finish;
	endtask
	// one avalon transfer, held until waitrequest is low
	task av(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (wreq !== 1'b0 && k < 50);
		if (k >= 50) stop();
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// start, time busy, wait out acquisition, read the result
	task conv(input logic [31:0] c, input int n, input logic [31:0] e);
		int k;
		av(1'b1, acs_pkg::ADDR_CTRL, c);
		k = 0;
		while (lnk.busy !== 1'b1 && k < 10) begin
			@(negedge i_clk);
			k++;
		end
		if (k >= 10) stop();
		chk({31'h0, hold}, 32'h1);
		k = 0;
		while (lnk.busy === 1'b1 && k < 2000) begin
			@(negedge i_clk);
			k++;
		end
		if (k >= 2000) stop();
		chk(k, n);
		chk({31'h0, hold}, 32'h0);
		chk({31'h0, lnk.powered}, {31'h0, !c[acs_pkg::CTRL_HOLD]});
		repeat (25) @(posedge i_clk);
		av(1'b0, acs_pkg::ADDR_RESULT, 32'h0);
		chk(q, e);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk({29'h0, chan}, 32'h0);
		av(1'b0, 32'h40, 32'h0);
		chk(q, 32'h0);
		av(1'b1, acs_pkg::ADDR_MASK, 32'h3);
		tc <= 10'(4 * (0 + 103));
		conv(32'h1, acs_pkg::CYC_CONV_TMP, 32'h19c);
		chk({31'h0, irq}, 32'h1);
		av(1'b1, acs_pkg::ADDR_CTRL, 32'h1);
		av(1'b1, acs_pkg::ADDR_CTRL, 32'h1);
		repeat (1400) @(posedge i_clk);
		av(1'b0, acs_pkg::ADDR_IRQ, 32'h0);
		chk(q, 32'h3);
		@(negedge i_clk);
		chk({31'h0, irq}, 32'h0);
		av(1'b1, acs_pkg::ADDR_MASK, 32'h0);
		av(1'b1, acs_pkg::ADDR_CTLBYTE, 32'h1);
		av(1'b1, acs_pkg::ADDR_CTLBYTE, 32'h8);
		// the pulse reaches the device end one edge after the write
		repeat (2) @(negedge i_clk);
		chk({21'h0, chan, thr}, 32'h108);
		av(1'b1, acs_pkg::ADDR_CTRL, 32'h1);
		av(1'b0, acs_pkg::ADDR_IRQ, 32'h0);
		chk({irq, q[30:0]}, 32'h2);
		smp <= 10'h2a5;
		repeat (25) @(posedge i_clk);
		conv(32'h1, acs_pkg::CYC_CONV_ANA, 32'h2a5);
		av(1'b1, acs_pkg::ADDR_CTLBYTE, 32'h7);
		repeat (25) @(posedge i_clk);
		conv(32'h1, acs_pkg::CYC_CONV_ANA, 32'h200);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk({29'h0, chan}, 32'h0);
		tc <= 10'(4 * (25 + 103));
		conv(32'h3, acs_pkg::CYC_CONV_TMP, 32'h200);
		chk({31'h0, lnk.powered}, 32'h1);
		av(1'b1, acs_pkg::ADDR_CTRL, 32'h0);
		repeat (3) @(posedge i_clk);
		chk({31'h0, lnk.powered}, 32'h1);
		av(1'b0, acs_pkg::ADDR_STATUS, 32'h0);
		chk(q, 32'h4);
		tally_and_finish;
	end
endmodule

// File: core/acs_dev.sv
// module: converter sequencer, device end
`timescale 1ns/1ps
module acs_dev (
	input wire logic i_clk,
	input wire logic i_rst_n,
	acs_if.dev lnk,
	input wire logic [9:0] i_sample,
	input wire logic [9:0] i_temp_code,
	output logic o_hold,
	output logic [2:0] o_channel_select,
	output logic [7:0] o_overtemp_threshold
);
	typedef struct packed {
		acs_pkg::acs_dev_st_t st;
		logic [10:0] cnt;
		logic start_d;
		logic hold;
		logic powered;
		logic [2:0] ch;
		logic [7:0] thresh;
		logic [9:0] res;
	} acs_dev_s_t;
	acs_dev_s_t s_ff, nxt_s;
	logic start_fall;
	logic [10:0] conv_len;
	// start edge detection and conversion length
	assign start_fall = s_ff.start_d & ~lnk.conversion_start_n;
	assign conv_len = (s_ff.ch == acs_pkg::CH_TEMP) ?
		11'(acs_pkg::CYC_CONV_TMP) : 11'(acs_pkg::CYC_CONV_ANA);
	// next-state logic
	always_comb begin
		nxt_s = s_ff;
		nxt_s.start_d = lnk.conversion_start_n;
		// control byte routing
		if (lnk.ctl_we) begin
			if (lnk.ctl_byte[7:3] == 5'h00) begin
				nxt_s.ch = lnk.ctl_byte[2:0]; // [R15] [R05]
			end else begin
				nxt_s.thresh = lnk.ctl_byte; // [R15]
			end
		end
		case (s_ff.st)
			acs_pkg::DEV_ACQ: begin
				// acquiring; a falling start edge samples
				if (start_fall) begin
					nxt_s.hold = 1'b1; // [R01]
					nxt_s.cnt = 11'h000; // [R03]
					nxt_s.st = acs_pkg::DEV_CONV;
				end
			end
			acs_pkg::DEV_CONV: begin
				// internally timed; start edges ignored [R19]
				nxt_s.cnt = s_ff.cnt + 11'h001; // [R03]
				if (s_ff.cnt == conv_len - 11'h001) begin // [R02]
					nxt_s.hold = 1'b0; // [R10]
					if (s_ff.ch == acs_pkg::CH_TEMP) begin
						nxt_s.res = i_temp_code; // [R04] [R08] [R09]
					end else if (s_ff.ch == acs_pkg::CH_BANDGAP) begin
						nxt_s.res = acs_pkg::MIDSCALE; // [R16]
					end else begin
						nxt_s.res = i_sample; // [R07] [R16]
					end
					if (!lnk.conversion_start_n) begin
						nxt_s.powered = 1'b0; // [R17]
						nxt_s.st = acs_pkg::DEV_DOWN;
					end else begin
						nxt_s.st = acs_pkg::DEV_ACQ;
					end
				end
			end
			acs_pkg::DEV_DOWN: begin
				// powered down until start rises
				if (lnk.conversion_start_n) begin
					nxt_s.powered = 1'b1; // [R17]
					nxt_s.st = acs_pkg::DEV_ACQ;
				end
			end
			default: begin
				nxt_s.st = acs_pkg::DEV_ACQ;
			end
		endcase
	end
	// state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_ff <= '{st: acs_pkg::DEV_ACQ, cnt: 11'h000, start_d: 1'b1,
				hold: 1'b0, powered: 1'b1, ch: acs_pkg::CH_RESET, // [R06]
				thresh: acs_pkg::THRESH_RESET, res: 10'h000};
		end else begin
			s_ff <= nxt_s;
		end
	end
	// outputs
	assign lnk.busy = (s_ff.st == acs_pkg::DEV_CONV); // [R02]
	assign lnk.result = s_ff.res; // [R19]
	assign lnk.powered = s_ff.powered;
	assign o_hold = s_ff.hold;
	assign o_channel_select = s_ff.ch;
	assign o_overtemp_threshold = s_ff.thresh;
endmodule

// File: core/acs_hst.sv
// module: host end with avalon-mm register slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module acs_hst (
	input wire logic i_clk,
	input wire logic i_rst_n,
	acs_if.hst lnk,
	input wire logic [31:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_irq
);
	typedef struct packed {
		acs_pkg::acs_hst_st_t st;
		logic [4:0] acq;
		logic start_n;
		logic auto_pd;
		logic [7:0] ctl;
		logic ctl_we;
		logic [9:0] res;
		logic [1:0] sts;
		logic [1:0] msk;
		logic [31:0] rd;
		logic ack;
	} acs_hst_s_t;
	acs_hst_s_t s_ff, nxt_s;
	logic acc;
	logic wen;
	logic go;
	logic [1:0] ev;
	// one-cycle answer: waitrequest high until ack register set
	assign acc = (i_read | i_write) & ~s_ff.ack;
	// writes land only at the edge where waitrequest is seen low
	assign wen = i_write & s_ff.ack;
	assign go = wen & (i_address == acs_pkg::ADDR_CTRL) &
		i_writedata[acs_pkg::CTRL_START];
	always_comb begin
		nxt_s = s_ff;
		ev = 2'b00;
		nxt_s.ack = acc;
		nxt_s.ctl_we = 1'b0;
		if (s_ff.acq != 5'h00) begin
			nxt_s.acq = s_ff.acq - 5'h01;
		end
		case (s_ff.st)
			acs_pkg::HST_IDLE: begin
				// a start during the acquisition wait is refused with an error [R11] [R12]
				if (go) begin
					if (s_ff.acq == 5'h00) begin
						nxt_s.start_n = 1'b0;
						nxt_s.auto_pd = i_writedata[acs_pkg::CTRL_HOLD];
						nxt_s.st = acs_pkg::HST_LOW;
					end else begin
						ev[acs_pkg::IRQ_ERR] = 1'b1;
					end
				end
			end
			acs_pkg::HST_LOW: begin
				// keep start low until busy is seen, or to end in power-down
				if (lnk.busy) begin
					nxt_s.start_n = s_ff.auto_pd ? 1'b0 : 1'b1; // [R14] [R18]
					nxt_s.st = acs_pkg::HST_BUSY;
				end
			end
			acs_pkg::HST_BUSY: begin
				if (!lnk.busy) begin
					nxt_s.res = lnk.result; // [R13]
					nxt_s.start_n = 1'b1; // [R17]
					nxt_s.acq = 5'(acs_pkg::CYC_ACQ); // [R12]
					ev[acs_pkg::IRQ_DONE] = 1'b1; // [R13]
					nxt_s.st = acs_pkg::HST_IDLE;
				end
			end
			default: begin
				nxt_s.st = acs_pkg::HST_IDLE;
			end
		endcase
		if (go && s_ff.st != acs_pkg::HST_IDLE) begin
			ev[acs_pkg::IRQ_ERR] = 1'b1;
		end
		// control byte write restarts acquisition wait [R12]
		if (wen && i_address == acs_pkg::ADDR_CTLBYTE) begin
			nxt_s.ctl = i_writedata[7:0];
			nxt_s.ctl_we = 1'b1;
			nxt_s.acq = 5'(acs_pkg::CYC_ACQ);
		end
		if (wen && i_address == acs_pkg::ADDR_MASK) begin
			nxt_s.msk = i_writedata[1:0];
		end
		nxt_s.rd = 32'h00000000;
		if (acc && i_read) begin
			case (i_address)
				acs_pkg::ADDR_STATUS: nxt_s.rd = {29'h0, lnk.powered,
					lnk.busy, s_ff.st != acs_pkg::HST_IDLE};
				acs_pkg::ADDR_RESULT: nxt_s.rd = {22'h0, s_ff.res};
				acs_pkg::ADDR_IRQ: nxt_s.rd = {30'h0, s_ff.sts};
				acs_pkg::ADDR_MASK: nxt_s.rd = {30'h0, s_ff.msk};
				acs_pkg::ADDR_CTLBYTE: nxt_s.rd = {24'h0, s_ff.ctl};
				default: nxt_s.rd = 32'h00000000;
			endcase
		end
		// read clears, new event wins
		if (acc && i_read && i_address == acs_pkg::ADDR_IRQ) begin
			nxt_s.sts = ev;
		end else begin
			nxt_s.sts = s_ff.sts | ev;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_ff <= '{st: acs_pkg::HST_IDLE, acq: 5'h00, start_n: 1'b1,
				auto_pd: 1'b0, ctl: 8'h00, ctl_we: 1'b0, res: 10'h000,
				sts: 2'b00, msk: 2'b00, rd: 32'h00000000, ack: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign lnk.conversion_start_n = s_ff.start_n;
	assign lnk.ctl_byte = s_ff.ctl;
	assign lnk.ctl_we = s_ff.ctl_we;
	assign o_readdata = s_ff.rd;
	assign o_waitrequest = ~s_ff.ack;
	assign o_irq = |(s_ff.sts & s_ff.msk);
endmodule

// File: core/acs_if.sv
// interface: conversion start, busy, control byte and result wires
`timescale 1ns/1ps
interface acs_if;
	logic conversion_start_n;
	logic busy;
	logic [7:0] ctl_byte;
	logic ctl_we;
	logic [9:0] result;
	logic powered;
	modport dev (input conversion_start_n, input ctl_byte, input ctl_we,
		output busy, output result, output powered);
	modport hst (output conversion_start_n, output ctl_byte,
		output ctl_we, input busy, input result, input powered);
endinterface

// File: core/acs_pkg.sv
// package: constants and types shared by the converter sequencer ends
// Behaviour
// R01: conversion-start fall puts track/hold in hold
// R02: busy high for 9us analog, 27us temperature
// R03: conversions timed by internal clock, not serial
// R04: channel zero conversion yields temperature code
// R05: channel address zero selects temperature sensor
// R06: channel defaults to temperature sensor after reset
// R07: results are 10-bit straight binary codes
// R08: temperature code equals four times (degC plus 103)
// R09: 0 degC gives 0x19c, 25 degC gives 0x200
// R10: acquisition restarts at end of conversion
// R11: host waits 100ns acquisition after busy falls
// R12: host waits 400ns after end or channel change
// R13: host reads result only after busy low
// R14: host prefers automatic power-down mode; the host powers down only for a start written with CTRL_HOLD set
// R15: control byte top five zero loads channel address
// R16: addresses 1..4 analog, 7 internal bandgap
// R17: start low at busy fall powers down until rise
// R18: start high before busy fall keeps device powered
// R19: result held until next conversion; starts ignored while busy
package acs_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned T_CONV_ANA_NS = 9000;
	localparam int unsigned T_CONV_TMP_NS = 27000;
	localparam int unsigned T_ACQ_SETTLE_NS = 100;
	localparam int unsigned T_ACQ_TH_NS = 400;
	localparam int unsigned NS_PER_CLK = 1000000000 / CLK_HZ;
	// longest times round down, least times round up
	localparam int unsigned CYC_CONV_ANA = T_CONV_ANA_NS / NS_PER_CLK;
	localparam int unsigned CYC_CONV_TMP = T_CONV_TMP_NS / NS_PER_CLK;
	localparam int unsigned CYC_ACQ =
		(T_ACQ_TH_NS + NS_PER_CLK - 1) / NS_PER_CLK;
	localparam int unsigned RES_W = 10;
	localparam int unsigned CH_W = 3;
	localparam int unsigned CNT_W = 11;
	localparam int unsigned CTL_W = 8;
	localparam logic [2:0] CH_TEMP = 3'h0;
	localparam logic [2:0] CH_BANDGAP = 3'h7;
	localparam logic [2:0] CH_RESET = CH_TEMP;
	localparam logic [9:0] TEMP_OFFSET_C = 10'h067; // 103 degrees
	localparam logic [9:0] MIDSCALE = 10'h200;
	localparam logic [7:0] THRESH_RESET = 8'h99; // 50 degrees plus 103
	localparam logic [31:0] ADDR_CTRL = 32'h00000000;
	localparam logic [31:0] ADDR_STATUS = 32'h00000004;
	localparam logic [31:0] ADDR_RESULT = 32'h00000008;
	localparam logic [31:0] ADDR_IRQ = 32'h0000000c;
	localparam logic [31:0] ADDR_MASK = 32'h00000010;
	localparam logic [31:0] ADDR_CTLBYTE = 32'h00000014;
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_HOLD = 1;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_ERR = 1;
	typedef enum logic [3:0] {
		DEV_ACQ = 4'h1,
		DEV_CONV = 4'h2,
		DEV_WAIT_HI = 4'h4,
		DEV_DOWN = 4'h8
	} acs_dev_st_t;
	typedef enum logic [3:0] {
		HST_IDLE = 4'h1,
		HST_LOW = 4'h2,
		HST_BUSY = 4'h4,
		HST_ACQ = 4'h8
	} acs_hst_st_t;
endpackage
